// ### rtl/qit_map.svh
// register offsets, field positions, reset values and prescaler taps of the quad interval timer
`ifndef QIT_MAP_SVH
`define QIT_MAP_SVH

// --------------------------------------------------------------
// register offsets (one 8-bit register per address)
// --------------------------------------------------------------
`define QIT_ADDR_CMP0     4'h0
`define QIT_ADDR_CMP1     4'h1
`define QIT_ADDR_CMP2     4'h2
`define QIT_ADDR_CMP3     4'h3
`define QIT_ADDR_TOGGLE   4'h4
`define QIT_ADDR_MODE     4'h5
`define QIT_ADDR_CLKSEL   4'h6
`define QIT_ADDR_RUN      4'h7

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define QIT_TOG_SOFT_HI   1
`define QIT_TOG_SOFT_LO   0
`define QIT_TOG_EN        2
`define QIT_TOG_SEL       3
`define QIT_TOG_LATCH2    4
`define QIT_TOG_LATCH3    5
`define QIT_MODE_P0_HI    1
`define QIT_MODE_P0_LO    0
`define QIT_MODE_P1_HI    3
`define QIT_MODE_P1_LO    2
`define QIT_MODE_PIN_EN   4

// --------------------------------------------------------------
// reset values and constant read values
// --------------------------------------------------------------
`define QIT_CMP_RST       8'h00
`define QIT_CLKSEL_RST    8'h00
`define QIT_RUN_RST       4'h0
`define QIT_RD_ZERO       8'h00
`define QIT_CNT_ZERO      8'h00
`define QIT_CNT_ONE       8'h01
`define QIT_CNT_MAX       8'hff
`define QIT_SOFT_RD       2'h3

// --------------------------------------------------------------
// prescaler taps: a tap fires when all masked bits are one
// --------------------------------------------------------------
`define QIT_PRESC_MIN_W   11
`define QIT_PRESC_ONE     11'h001
`define QIT_TAP_DIV2      11'h001
`define QIT_TAP_DIV8      11'h007
`define QIT_TAP_DIV128    11'h07f
`define QIT_TAP_DIV2048   11'h7ff

`endif

// ### rtl/qit_pkg.sv
// types shared by the quad interval timer
package qit_pkg;

  // operating mode of one timer pair
  typedef enum logic [1:0] {
    QIT_PAIR_8BIT  = 2'b00,
    QIT_PAIR_16BIT = 2'b01,
    QIT_PAIR_PPG   = 2'b10,
    QIT_PAIR_PWM   = 2'b11
  } qit_pair_mode_e;

  // software control of the shared output flip-flop
  typedef enum logic [1:0] {
    QIT_FF_CLEAR  = 2'b00,
    QIT_FF_SET    = 2'b01,
    QIT_FF_INVERT = 2'b10,
    QIT_FF_KEEP   = 2'b11
  } qit_ffctl_e;

endpackage

// ### rtl/qit_quad_timer.sv
// quad 8-bit interval timer with cascade pairs and shared toggle output
//
// What this block does
// - match on equality; zero matches on overflow
// - compare writes reach comparator immediately
// - timer 0/1 compare registers are write-only
// - timer 2/3 read latch, write compare
// - 8-bit match clears counter, raises interrupt
// - enabled match inverts flip-flop, drives pin
// - select bit picks timer 0 or 1; 16-bit mode uses timer 1
// - toggle enable gates match inversion, resets to zero
// - soft field clears, sets or inverts flip-flop
// - flip-flop state never readable
// - four timers independent; 2/3 no output
// - timer 1 may count timer 0 matches
// - prescaler taps include system clock div8
// - pair mode 01 cascades via timer 0 overflow
// - timers 2/3 cascade the same way
// - timer 0 low byte, timer 1 high byte
// - low byte write suspends until high byte
// - 16-bit low match interrupts without clearing
// - 16-bit full match clears both, timer 1 interrupt
// - clearing run bit stops and zeroes counter
// - repeated toggles give 50 percent square wave
`timescale 1ns/1ps
`default_nettype none
`include "qit_map.svh"

module qit_quad_timer #(
  parameter int unsigned PRESCALE_W = 11
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            timer0_irq,
  output logic            timer1_irq,
  output logic            timer2_irq,
  output logic            timer3_irq,
  output logic            timer_output_pin,
  output logic            timer_output_pin_oe
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (PRESCALE_W < `QIT_PRESC_MIN_W) begin : g_bad_presc
    $error("prescaler narrower than the widest tap");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [PRESCALE_W-1:0]   presc_reg;
  logic [PRESCALE_W-1:0]   presc_next;
  logic [7:0]              cnt_reg    [0:3];
  logic [7:0]              cnt_next   [0:3];
  logic [7:0]              cmp_reg    [0:3];
  logic [7:0]              cmp_next   [0:3];
  logic [7:0]              latch_reg  [0:1];
  logic [7:0]              latch_next [0:1];
  logic [1:0]              armed_reg;
  logic [1:0]              armed_next;
  qit_pkg::qit_pair_mode_e pmode_reg  [0:1];
  qit_pkg::qit_pair_mode_e pmode_next [0:1];
  logic                    pin_en_reg;
  logic                    pin_en_next;
  logic [7:0]              clksel_reg;
  logic [7:0]              clksel_next;
  logic [3:0]              run_reg;
  logic [3:0]              run_next;
  logic                    tog_en_reg;
  logic                    tog_en_next;
  logic                    tog_sel_reg;
  logic                    tog_sel_next;
  logic                    ff_reg;
  logic                    ff_next;
  logic [3:0]              irq_reg;
  logic [3:0]              irq_next;
  logic [7:0]              rdata_reg;
  logic [7:0]              rdata_next;

  // ------------------------------------------------------------
  // combinational helpers
  // ------------------------------------------------------------
  logic [3:0]  tick_c;
  logic [3:0]  match_c;
  logic        hw_toggle_c;
  logic        tog_wr_c;
  logic [7:0]  inc_c     [0:3];

  // prescaler tap selected by a two-bit source code
  function automatic logic tap_hit(input logic [1:0] sel, input logic [`QIT_PRESC_MIN_W-1:0] pre);
    logic [`QIT_PRESC_MIN_W-1:0] mask;
    mask = `QIT_TAP_DIV2;
    unique case (sel)
      2'b00: mask = `QIT_TAP_DIV2;
      2'b01: mask = `QIT_TAP_DIV8;
      2'b10: mask = `QIT_TAP_DIV128;
      2'b11: mask = `QIT_TAP_DIV2048;
    endcase
    return (pre & mask) == mask;
  endfunction

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------

  // free-running divider feeding all taps
  always_comb
  begin
    presc_next = presc_reg + PRESCALE_W'(`QIT_PRESC_ONE);
  end

  // ------------------------------------------------------------
  // counters and comparators
  // ------------------------------------------------------------

  // per pair: count sources, matches and next counter values
  always_comb
  begin
    tick_c  = 4'h0;
    match_c = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      cnt_next[i] = cnt_reg[i];
      inc_c[i]    = cnt_reg[i] + `QIT_CNT_ONE;
    end
    for (int p = 0; p < 2; p++)
    begin
      tick_c[2*p] = run_reg[2*p] && tap_hit(clksel_reg[4*p +: 2], presc_reg[`QIT_PRESC_MIN_W-1:0]);
      if (pmode_reg[p] == qit_pkg::QIT_PAIR_16BIT)
      begin
        // cascade: low overflow clocks the high counter
        tick_c[2*p+1] = run_reg[2*p+1] && tick_c[2*p] && (cnt_reg[2*p] == `QIT_CNT_MAX);
        match_c[2*p]  = armed_reg[p] && tick_c[2*p] && (inc_c[2*p] == cmp_reg[2*p]);
        // low byte from the low timer, high byte from the high timer
        match_c[2*p+1] = armed_reg[p] && tick_c[2*p] && run_reg[2*p+1]
                         && (16'({cnt_reg[2*p+1], cnt_reg[2*p]} + 16'h0001)
                             == {cmp_reg[2*p+1], cmp_reg[2*p]});
        if (match_c[2*p+1])
        begin
          cnt_next[2*p]   = `QIT_CNT_ZERO;
          cnt_next[2*p+1] = `QIT_CNT_ZERO;
        end
        else
        begin
          // a low match alone keeps counting
          if (tick_c[2*p])
            cnt_next[2*p] = inc_c[2*p];
          if (tick_c[2*p+1])
            cnt_next[2*p+1] = inc_c[2*p+1];
        end
      end
      else
      begin
        // independent 8-bit timers; source 00 of the high one is the low match
        match_c[2*p] = tick_c[2*p] && (inc_c[2*p] == cmp_reg[2*p]);
        if (clksel_reg[4*p+2 +: 2] == 2'b00)
          tick_c[2*p+1] = run_reg[2*p+1] && match_c[2*p];
        else
          tick_c[2*p+1] = run_reg[2*p+1] && tap_hit(clksel_reg[4*p+2 +: 2], presc_reg[`QIT_PRESC_MIN_W-1:0]);
        match_c[2*p+1] = tick_c[2*p+1] && (inc_c[2*p+1] == cmp_reg[2*p+1]);
        for (int k = 0; k < 2; k++)
        begin
          if (match_c[2*p+k])
            cnt_next[2*p+k] = `QIT_CNT_ZERO;
          else if (tick_c[2*p+k])
            cnt_next[2*p+k] = inc_c[2*p+k];
        end
      end
    end
    // stopped timers hold zero
    for (int i = 0; i < 4; i++)
    begin
      if (!run_reg[i])
        cnt_next[i] = `QIT_CNT_ZERO;
    end
  end

  // one interrupt pulse per match
  always_comb
  begin
    irq_next = match_c;
  end

  // ------------------------------------------------------------
  // shared output flip-flop (timers 0 and 1 only)
  // ------------------------------------------------------------

  // match that inverts the flip-flop
  always_comb
  begin
    if (pmode_reg[0] == qit_pkg::QIT_PAIR_16BIT)
      hw_toggle_c = tog_en_reg && match_c[1];
    else
      hw_toggle_c = tog_en_reg && (tog_sel_reg ? match_c[1] : match_c[0]);
  end

  // software set/clear wins; software and match inversions combine
  always_comb
  begin
    tog_wr_c = reg_wr && (reg_addr == `QIT_ADDR_TOGGLE);
    ff_next  = ff_reg ^ hw_toggle_c;
    if (tog_wr_c)
    begin
      unique case (qit_pkg::qit_ffctl_e'(reg_wdata[`QIT_TOG_SOFT_HI:`QIT_TOG_SOFT_LO]))
        qit_pkg::QIT_FF_CLEAR:  ff_next = 1'b0;
        qit_pkg::QIT_FF_SET:    ff_next = 1'b1;
        qit_pkg::QIT_FF_INVERT: ff_next = ~ff_reg ^ hw_toggle_c;
        qit_pkg::QIT_FF_KEEP:   ff_next = ff_reg ^ hw_toggle_c;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------

  // register writes
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      cmp_next[i] = cmp_reg[i];
    for (int k = 0; k < 2; k++)
    begin
      latch_next[k] = latch_reg[k];
      pmode_next[k] = pmode_reg[k];
    end
    armed_next   = armed_reg;
    pin_en_next  = pin_en_reg;
    clksel_next  = clksel_reg;
    run_next     = run_reg;
    tog_en_next  = tog_en_reg;
    tog_sel_next = tog_sel_reg;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `QIT_ADDR_CMP0, `QIT_ADDR_CMP2:
        begin
          cmp_next[reg_addr[1:0]]   = reg_wdata;
          armed_next[reg_addr[1]]   = 1'b0;
        end
        `QIT_ADDR_CMP1, `QIT_ADDR_CMP3:
        begin
          cmp_next[reg_addr[1:0]]   = reg_wdata;
          armed_next[reg_addr[1]]   = 1'b1;
        end
        `QIT_ADDR_TOGGLE:
        begin
          tog_en_next  = reg_wdata[`QIT_TOG_EN];
          tog_sel_next = reg_wdata[`QIT_TOG_SEL];
          // a zero in a trigger bit snapshots the counter
          if (!reg_wdata[`QIT_TOG_LATCH2])
            latch_next[0] = cnt_reg[2];
          if (!reg_wdata[`QIT_TOG_LATCH3])
            latch_next[1] = cnt_reg[3];
        end
        `QIT_ADDR_MODE:
        begin
          pmode_next[0] = qit_pkg::qit_pair_mode_e'(reg_wdata[`QIT_MODE_P0_HI:`QIT_MODE_P0_LO]);
          pmode_next[1] = qit_pkg::qit_pair_mode_e'(reg_wdata[`QIT_MODE_P1_HI:`QIT_MODE_P1_LO]);
          pin_en_next   = reg_wdata[`QIT_MODE_PIN_EN];
        end
        `QIT_ADDR_CLKSEL: clksel_next = reg_wdata;
        `QIT_ADDR_RUN:    run_next    = reg_wdata[3:0];
        default:
        begin
        end
      endcase
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb
  begin
    rdata_next = `QIT_RD_ZERO;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `QIT_ADDR_CMP0, `QIT_ADDR_CMP1: rdata_next = `QIT_RD_ZERO;
        `QIT_ADDR_CMP2:   rdata_next = latch_reg[0];
        `QIT_ADDR_CMP3:   rdata_next = latch_reg[1];
        // flip-flop state is never returned
        `QIT_ADDR_TOGGLE: rdata_next = {2'b00, 1'b1, 1'b1, tog_sel_reg, tog_en_reg, `QIT_SOFT_RD};
        `QIT_ADDR_MODE:   rdata_next = {3'b000, pin_en_reg, pmode_reg[1], pmode_reg[0]};
        `QIT_ADDR_CLKSEL: rdata_next = clksel_reg;
        `QIT_ADDR_RUN:    rdata_next = {4'h0, run_reg};
        default:          rdata_next = `QIT_RD_ZERO;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------

  // all state registered here with synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      presc_reg   <= '0;
      for (int i = 0; i < 4; i++)
      begin
        cnt_reg[i] <= `QIT_CNT_ZERO;
        cmp_reg[i] <= `QIT_CMP_RST;
      end
      for (int k = 0; k < 2; k++)
      begin
        latch_reg[k] <= `QIT_CNT_ZERO;
        pmode_reg[k] <= qit_pkg::QIT_PAIR_8BIT;
      end
      armed_reg   <= 2'b11;
      pin_en_reg  <= 1'b0;
      clksel_reg  <= `QIT_CLKSEL_RST;
      run_reg     <= `QIT_RUN_RST;
      tog_en_reg  <= 1'b0;
      tog_sel_reg <= 1'b0;
      ff_reg      <= 1'b0;
      irq_reg     <= 4'h0;
      rdata_reg   <= `QIT_RD_ZERO;
    end
    else
    begin
      presc_reg   <= presc_next;
      for (int i = 0; i < 4; i++)
      begin
        cnt_reg[i] <= cnt_next[i];
        cmp_reg[i] <= cmp_next[i];
      end
      for (int k = 0; k < 2; k++)
      begin
        latch_reg[k] <= latch_next[k];
        pmode_reg[k] <= pmode_next[k];
      end
      armed_reg   <= armed_next;
      pin_en_reg  <= pin_en_next;
      clksel_reg  <= clksel_next;
      run_reg     <= run_next;
      tog_en_reg  <= tog_en_next;
      tog_sel_reg <= tog_sel_next;
      ff_reg      <= ff_next;
      irq_reg     <= irq_next;
      rdata_reg   <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata           = rdata_reg;
  assign timer0_irq          = irq_reg[0];
  assign timer1_irq          = irq_reg[1];
  assign timer2_irq          = irq_reg[2];
  assign timer3_irq          = irq_reg[3];
  assign timer_output_pin    = ff_reg;
  assign timer_output_pin_oe = pin_en_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_soft_set;
    reg_wr && (reg_addr == `QIT_ADDR_TOGGLE) && (reg_wdata[1:0] == 2'b01);
  endsequence

  sequence s_sel0_match;
    tog_en_reg && !tog_sel_reg && !tog_wr_c && (pmode_reg[0] == qit_pkg::QIT_PAIR_8BIT)
      && match_c[0] && !match_c[1];
  endsequence

  AST_MATCH_CLEARS_8BIT: assert property (
    (pmode_reg[1] != qit_pkg::QIT_PAIR_16BIT && tick_c[2] && 8'(cnt_reg[2] + 8'h01) == cmp_reg[2])
      |=> (cnt_reg[2] == 8'h00) && timer2_irq)
    else $error("timer 2 match did not clear and interrupt");

  AST_WO_READ: assert property (
    (reg_rd && reg_addr == `QIT_ADDR_CMP0 && cmp_reg[0] != 8'h00) |=> reg_rdata == 8'h00)
    else $error("compare 0 value leaked on read");

  AST_LATCH_READ: assert property (
    (reg_rd && reg_addr == `QIT_ADDR_CMP2) |=> reg_rdata == $past(latch_reg[0]))
    else $error("timer 2 address did not return latch");

  AST_CMP_IMMEDIATE: assert property (
    (reg_wr && reg_addr == `QIT_ADDR_CMP3) |=> cmp_reg[3] == $past(reg_wdata))
    else $error("compare write not applied at once");

  AST_RUN_STOP: assert property (
    (reg_wr && reg_addr == `QIT_ADDR_RUN && !reg_wdata[0]) |=> ##1 cnt_reg[0] == 8'h00)
    else $error("stopped timer 0 counter not zero");

  AST_SOFT_SET: assert property (
    s_soft_set |=> timer_output_pin)
    else $error("soft set did not set output flip-flop");

  AST_TOGGLE_BLOCK: assert property (
    (!tog_en_reg && !tog_wr_c) |=> $stable(ff_reg))
    else $error("flip-flop moved while toggling disabled");

  AST_SEL0_TOGGLE: assert property (
    s_sel0_match |=> ff_reg != $past(ff_reg))
    else $error("timer 0 match did not invert flip-flop");

  AST_LOW_SUSPEND: assert property (
    (pmode_reg[0] == qit_pkg::QIT_PAIR_16BIT && reg_wr && reg_addr == `QIT_ADDR_CMP0)
      |=> !armed_reg[0] && !match_c[1])
    else $error("16-bit comparator not suspended");

  AST_LOW_NO_CLEAR: assert property (
    (pmode_reg[0] == qit_pkg::QIT_PAIR_16BIT && match_c[0] && !match_c[1] && run_reg[0])
      |=> timer0_irq && cnt_reg[0] == 8'($past(cnt_reg[0]) + 8'h01))
    else $error("16-bit low match cleared counter");

  AST_FULL_MATCH: assert property (
    (pmode_reg[0] == qit_pkg::QIT_PAIR_16BIT && match_c[1])
      |=> timer1_irq && cnt_reg[0] == 8'h00 && cnt_reg[1] == 8'h00)
    else $error("16-bit match did not clear both counters");

endmodule // qit_quad_timer

`default_nettype wire

// ### verif/tb_top.sv
// self-checking testbench of the quad interval timer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  `include "qit_map.svh"

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic       core_clk;
  logic       nrst;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [3:0] irq;
  logic       pin;
  logic       pin_oe;
  int         bad_count;
  int         checks_done;

  qit_quad_timer dut (
    .core_clk            (core_clk),
    .nrst                (nrst),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .timer0_irq          (irq[0]),
    .timer1_irq          (irq[1]),
    .timer2_irq          (irq[2]),
    .timer3_irq          (irq[3]),
    .timer_output_pin    (pin),
    .timer_output_pin_oe (pin_oe)
  );

  // 50 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // read, data judged in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  // cycles between two interrupt pulses of one timer
  task automatic period(input int i, input int exp);
    int n;
    n = 0;
    while (irq[i] !== 1'b1 && n < 1200)
    begin
      @(negedge core_clk);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end while (irq[i] !== 1'b1 && n < 1200);
    chk($sformatf("irq%0d period", i), 16'(exp), 16'(n));
  endtask

  // cycles between two changes of the output pin
  task automatic pin_half(input int exp);
    int   n;
    logic p;
    n = 0;
    p = pin;
    while (pin === p && n < 1200)
    begin
      @(negedge core_clk);
      n++;
    end
    p = pin;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end while (pin === p && n < 1200);
    chk("pin half period", 16'(exp), 16'(n));
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // reset state and register access kinds
  task automatic t_reset_regs();
    chk("pin/oe/irq", 16'h0000, {10'h000, pin, pin_oe, irq});
    rd(`QIT_ADDR_TOGGLE, 8'h33, "toggle ctl reset");
    wr(`QIT_ADDR_CMP0, 8'h5a);
    rd(`QIT_ADDR_CMP0, 8'h00, "cmp0 read");
    wr(`QIT_ADDR_CMP1, 8'ha5);
    rd(`QIT_ADDR_CMP1, 8'h00, "cmp1 read");
    wr(`QIT_ADDR_CLKSEL, 8'h40);
    rd(`QIT_ADDR_CLKSEL, 8'h40, "clksel read");
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00, "unmapped read");
  endtask

  // four independent 8-bit timers, timer 1 fed by timer 0 matches
  task automatic t_eight_bit();
    wr(`QIT_ADDR_RUN, 8'h00);
    wr(`QIT_ADDR_MODE, 8'h00);
    wr(`QIT_ADDR_CLKSEL, 8'h40);
    wr(`QIT_ADDR_CMP0, 8'h03);
    wr(`QIT_ADDR_CMP1, 8'h02);
    wr(`QIT_ADDR_CMP2, 8'h05);
    wr(`QIT_ADDR_CMP3, 8'h02);
    wr(`QIT_ADDR_RUN, 8'h0f);
    period(0, 6);
    period(1, 12);
    period(2, 10);
    period(3, 16);
  endtask

  // compare value zero matches on overflow
  task automatic t_zero_cmp();
    wr(`QIT_ADDR_RUN, 8'h00);
    wr(`QIT_ADDR_CMP0, 8'h00);
    wr(`QIT_ADDR_RUN, 8'h01);
    period(0, 512);
  endtask

  // latch snapshots a running counter; stop clears it
  task automatic t_stop_latch();
    wr(`QIT_ADDR_CMP2, 8'h10);
    wr(`QIT_ADDR_RUN, 8'h04);
    period(2, 32);
    repeat (5) @(posedge core_clk);
    wr(`QIT_ADDR_TOGGLE, 8'h23);
    rd(`QIT_ADDR_CMP2, 8'h03, "latch running");
    wr(`QIT_ADDR_RUN, 8'h00);
    wr(`QIT_ADDR_TOGGLE, 8'h23);
    rd(`QIT_ADDR_CMP2, 8'h00, "latch after stop");
  endtask

  // software control of the output flip-flop
  task automatic t_soft_ff();
    wr(`QIT_ADDR_MODE, 8'h10);
    @(negedge core_clk);
    chk("pin oe", 16'h0001, {15'h0000, pin_oe});
    wr(`QIT_ADDR_TOGGLE, 8'h31);
    @(negedge core_clk);
    chk("pin set", 16'h0001, {15'h0000, pin});
    wr(`QIT_ADDR_TOGGLE, 8'h32);
    @(negedge core_clk);
    chk("pin invert", 16'h0000, {15'h0000, pin});
    wr(`QIT_ADDR_TOGGLE, 8'h32);
    @(negedge core_clk);
    chk("pin invert", 16'h0001, {15'h0000, pin});
    wr(`QIT_ADDR_TOGGLE, 8'h30);
    @(negedge core_clk);
    chk("pin clear", 16'h0000, {15'h0000, pin});
    rd(`QIT_ADDR_TOGGLE, 8'h33, "toggle ctl read");
  endtask

  // match-driven square wave from timer 0, gated by enable
  task automatic t_toggle();
    wr(`QIT_ADDR_CLKSEL, 8'h00);
    wr(`QIT_ADDR_CMP0, 8'h03);
    wr(`QIT_ADDR_TOGGLE, 8'h30);
    wr(`QIT_ADDR_RUN, 8'h01);
    repeat (14) @(posedge core_clk);
    chk("pin disabled", 16'h0000, {15'h0000, pin});
    wr(`QIT_ADDR_TOGGLE, 8'h37);
    rd(`QIT_ADDR_TOGGLE, 8'h37, "toggle ctl en");
    pin_half(6);
    pin_half(6);
    pin_half(6);
    wr(`QIT_ADDR_RUN, 8'h00);
  endtask

  // cascaded 16-bit pairs 0/1 and 2/3
  task automatic t_sixteen();
    wr(`QIT_ADDR_RUN, 8'h00);
    wr(`QIT_ADDR_MODE, 8'h11);
    wr(`QIT_ADDR_TOGGLE, 8'h3f);
    wr(`QIT_ADDR_CLKSEL, 8'hc0);
    wr(`QIT_ADDR_CMP0, 8'h02);
    wr(`QIT_ADDR_CMP1, 8'h01);
    wr(`QIT_ADDR_RUN, 8'h03);
    period(0, 512);
    period(1, 516);
    pin_half(516);
    wr(`QIT_ADDR_MODE, 8'h04);
    wr(`QIT_ADDR_CLKSEL, 8'h00);
    wr(`QIT_ADDR_CMP2, 8'h02);
    wr(`QIT_ADDR_CMP3, 8'h01);
    wr(`QIT_ADDR_RUN, 8'h0c);
    period(3, 516);
  endtask

  // ------------------------------------------------------------
  // verdict
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #400000;
    bad_count++;
    $display("unexpected run length: expected end seen timeout");
    wrap_up();
  end

  // main sequence
  initial
  begin
    bad_count   = 0;
    checks_done = 0;
    nrst        = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    t_reset_regs();
    t_eight_bit();
    t_zero_cmp();
    t_stop_latch();
    t_soft_ff();
    t_toggle();
    t_sixteen();
    wrap_up();
  end

endmodule // tb_top

`default_nettype wire
